// file: core/power_state_clock_gating.sv
// clock gating and clock-condition control driven by power state
//
// Summary of operation
// - OFF state stops every clock source except the low-frequency oscillator.
// - OFF state parks all I/O and memory pins at high impedance or low.
// - SUSPEND stops high-frequency oscillator; memory refresh keeps running.
// - SLEEP and DOZE keep oscillator on; throttler asks cycle generator to slow.
// - ON state runs the system clock at full speed, no throttling; expansion clock stays divided.
// - Three processor-clock stop conditions, each with its own enable bit.
// - Stop-on-HALT stops clock after HALT; hold request, interrupt, NMI restart.
// - Hold stop begins at hold acknowledge, ends when hold request drops.
// - Expansion stop begins when the cycle starts, ends when ready asserts.
// - Expansion and card cycles use expansion clock; memory uses processor clock.
// - Low-frequency clock always runs; sole oscillator in SUSPEND and OFF.
// - Throttler senses activity and slows system clock when idle in SLEEP or DOZE.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module power_state_clock_gating (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [clk_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] power_state,
  input wire logic system_activity,
  input wire logic halt_cycle,
  input wire logic hold_request,
  input wire logic hold_acknowledge,
  input wire logic interrupt_request,
  input wire logic nmi_request,
  input wire logic expansion_cycle,
  input wire logic rdy,
  output logic lf_osc_enable,
  output logic hf_osc_enable,
  output logic refresh_enable,
  output logic pad_park,
  output logic throttle_request,
  output logic sys_clk_en,
  output logic cpu_clk_en,
  output logic exp_clk_en,
  output logic cycle_clk_en,
  output logic cpu_clk_stopped,
  output logic [7:0] serial_clock_control,
  output logic [7:0] timer_clock_control_a,
  output logic [7:0] timer_clock_control_b
);
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] sio;
    logic [7:0] tma;
    logic [7:0] tmb;
    logic [7:0] cgc;
    logic [31:0] rdata;
    clk_pkg::cpu_state_e cpu;
    logic [clk_pkg::IDLE_W-1:0] idle_cnt;
    logic throttle;
    logic hf_on;
    logic park;
    logic refresh;
  } state_s;

  state_s cur_ff;
  state_s nxt_cur;

  // decode a byte address to an index; unaligned or unknown is unmapped
  function automatic logic addr_hit(
    input logic [clk_pkg::ADDR_W-1:0] a,
    input logic [7:0] idx
  );
    addr_hit = (a == {2'b00, idx, 2'b00});
  endfunction

  function automatic logic addr_mapped(
    input logic [clk_pkg::ADDR_W-1:0] a
  );
    addr_mapped = addr_hit(a, clk_pkg::IDX_CYCLE_GEN_MODE) ||
      addr_hit(a, clk_pkg::IDX_SERIAL_CLK) ||
      addr_hit(a, clk_pkg::IDX_TIMER_CLK_A) ||
      addr_hit(a, clk_pkg::IDX_TIMER_CLK_B) ||
      addr_hit(a, clk_pkg::IDX_CLK_GATING) ||
      addr_hit(a, clk_pkg::IDX_CLK_STATUS);
  endfunction

  logic ps_off;
  logic ps_suspend;
  logic ps_slow;
  logic thr_tick;
  logic exp_tick;
  logic sys_en;
  logic setup_phase;
  logic wr_take;
  logic wake;
  logic halt_en;
  logic hold_en;
  logic exp_en;
  logic [7:0] status;

  assign ps_off = (power_state == clk_pkg::PS_OFF);
  assign ps_suspend = (power_state == clk_pkg::PS_SUSPEND);
  assign ps_slow = (power_state == clk_pkg::PS_SLEEP) ||
    (power_state == clk_pkg::PS_DOZE);

  assign setup_phase = psel && !penable;
  assign wr_take = psel && penable && pwrite && addr_mapped(paddr);

  assign halt_en = cur_ff.cgc[clk_pkg::CGC_HALT_BIT];
  assign hold_en = cur_ff.cgc[clk_pkg::CGC_HOLD_BIT];
  assign exp_en = cur_ff.cgc[clk_pkg::CGC_EXP_BIT];
  assign wake = hold_request || interrupt_request || nmi_request;

  // throttled system rate; runs only while the oscillator is live
  rate_divider u_thr_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(cur_ff.hf_on),
    .ratio(cur_ff.mode[clk_pkg::MODE_THR_LSB +: clk_pkg::DIV_W]),
    .tick(thr_tick)
  );

  // expansion bus rate, independent of processor gating
  rate_divider u_exp_div (
    .pclk(pclk),
    .presetn(presetn),
    .run(cur_ff.hf_on),
    .ratio(cur_ff.mode[clk_pkg::MODE_EXP_LSB +: clk_pkg::DIV_W]),
    .tick(exp_tick)
  );

  always_comb begin
    if (!cur_ff.hf_on) begin
      sys_en = 1'b0;
    end else if (cur_ff.throttle) begin
      sys_en = thr_tick;
    end else begin
      sys_en = 1'b1;
    end
  end

  assign status = {cur_ff.hf_on, cur_ff.throttle,
    (cur_ff.cpu != clk_pkg::CPU_RUN), power_state};

  always_comb begin
    nxt_cur = cur_ff;
    // oscillator follows the power state, one register stage behind
    nxt_cur.hf_on = !(ps_off || ps_suspend);
    nxt_cur.park = ps_off;
    // refresh must survive suspend or memory contents are lost
    nxt_cur.refresh = !ps_off;
    // activity sensing: any activity restarts the idle window
    if (!ps_slow) begin
      nxt_cur.idle_cnt = '0;
      nxt_cur.throttle = 1'b0;
    end else if (system_activity) begin
      nxt_cur.idle_cnt = '0;
      nxt_cur.throttle = 1'b0;
    end else if (cur_ff.idle_cnt ==
      clk_pkg::IDLE_W'(clk_pkg::IDLE_CYCLES - 1)) begin
      nxt_cur.throttle = 1'b1;
    end else begin
      nxt_cur.idle_cnt = cur_ff.idle_cnt + 1'b1;
    end
    // processor clock stop machine
    case (cur_ff.cpu)
      clk_pkg::CPU_RUN: begin
        if (hold_en && hold_acknowledge) begin
          nxt_cur.cpu = clk_pkg::CPU_HOLD_STOP;
        end else if (exp_en && expansion_cycle && !rdy) begin
          nxt_cur.cpu = clk_pkg::CPU_EXP_STOP;
        end else if (halt_en && halt_cycle && !wake) begin
          nxt_cur.cpu = clk_pkg::CPU_HALT_STOP;
        end
      end
      clk_pkg::CPU_HALT_STOP: begin
        // clearing the enable also releases, so software cannot wedge it
        if (wake || !halt_en) begin
          nxt_cur.cpu = clk_pkg::CPU_RUN;
        end
      end
      clk_pkg::CPU_HOLD_STOP: begin
        if (!hold_request) begin
          nxt_cur.cpu = clk_pkg::CPU_RUN;
        end
      end
      clk_pkg::CPU_EXP_STOP: begin
        if (rdy) begin
          nxt_cur.cpu = clk_pkg::CPU_RUN;
        end
      end
      default: begin
        nxt_cur.cpu = clk_pkg::CPU_RUN;
      end
    endcase
    // register writes take effect at the access edge only
    if (wr_take) begin
      if (addr_hit(paddr, clk_pkg::IDX_CYCLE_GEN_MODE)) begin
        nxt_cur.mode = pwdata[7:0];
      end
      if (addr_hit(paddr, clk_pkg::IDX_SERIAL_CLK)) begin
        nxt_cur.sio = pwdata[7:0];
      end
      if (addr_hit(paddr, clk_pkg::IDX_TIMER_CLK_A)) begin
        nxt_cur.tma = pwdata[7:0];
      end
      if (addr_hit(paddr, clk_pkg::IDX_TIMER_CLK_B)) begin
        nxt_cur.tmb = pwdata[7:0];
      end
      if (addr_hit(paddr, clk_pkg::IDX_CLK_GATING)) begin
        nxt_cur.cgc = pwdata[7:0];
      end
    end
    // read data captured in setup so it leaves a flop in the access phase
    if (setup_phase) begin
      nxt_cur.rdata = '0;
      if (addr_hit(paddr, clk_pkg::IDX_CYCLE_GEN_MODE)) begin
        nxt_cur.rdata[7:0] = cur_ff.mode;
      end
      if (addr_hit(paddr, clk_pkg::IDX_SERIAL_CLK)) begin
        nxt_cur.rdata[7:0] = cur_ff.sio;
      end
      if (addr_hit(paddr, clk_pkg::IDX_TIMER_CLK_A)) begin
        nxt_cur.rdata[7:0] = cur_ff.tma;
      end
      if (addr_hit(paddr, clk_pkg::IDX_TIMER_CLK_B)) begin
        nxt_cur.rdata[7:0] = cur_ff.tmb;
      end
      if (addr_hit(paddr, clk_pkg::IDX_CLK_GATING)) begin
        nxt_cur.rdata[7:0] = cur_ff.cgc;
      end
      if (addr_hit(paddr, clk_pkg::IDX_CLK_STATUS)) begin
        nxt_cur.rdata[7:0] = status;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff.mode <= clk_pkg::RST_CYCLE_GEN_MODE;
      cur_ff.sio <= clk_pkg::RST_SERIAL_CLK;
      cur_ff.tma <= clk_pkg::RST_TIMER_CLK_A;
      cur_ff.tmb <= clk_pkg::RST_TIMER_CLK_B;
      cur_ff.cgc <= clk_pkg::RST_CLK_GATING;
      cur_ff.rdata <= '0;
      cur_ff.cpu <= clk_pkg::CPU_RUN;
      cur_ff.idle_cnt <= '0;
      cur_ff.throttle <= 1'b0;
      cur_ff.hf_on <= 1'b1;
      cur_ff.park <= 1'b0;
      cur_ff.refresh <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // zero-wait slave; an unmapped address errors in the access phase
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign prdata = cur_ff.rdata;

  assign lf_osc_enable = 1'b1;
  assign hf_osc_enable = cur_ff.hf_on;
  assign refresh_enable = cur_ff.refresh;
  assign pad_park = cur_ff.park;
  assign throttle_request = cur_ff.throttle;
  assign sys_clk_en = sys_en;
  assign cpu_clk_stopped = (cur_ff.cpu != clk_pkg::CPU_RUN);
  assign cpu_clk_en = sys_en && (cur_ff.cpu == clk_pkg::CPU_RUN);
  // expansion timing does not stop with the processor clock
  assign exp_clk_en = exp_tick && cur_ff.hf_on;
  assign cycle_clk_en = expansion_cycle ? exp_clk_en : cpu_clk_en;
  assign serial_clock_control = cur_ff.sio;
  assign timer_clock_control_a = cur_ff.tma;
  assign timer_clock_control_b = cur_ff.tmb;
endmodule

// file: core/clk_pkg.sv
// shared constants and types for the power-state clock gating block
package clk_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned REG_W = 8;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CYCLE_GEN_MODE = 8'h01;
  localparam logic [7:0] IDX_SERIAL_CLK = 8'h0f;
  localparam logic [7:0] IDX_TIMER_CLK_A = 8'h12;
  localparam logic [7:0] IDX_TIMER_CLK_B = 8'h13;
  localparam logic [7:0] IDX_CLK_GATING = 8'hde;
  localparam logic [7:0] IDX_CLK_STATUS = 8'h20;
  // clock_gating_control fields
  localparam int unsigned CGC_HALT_BIT = 0;
  localparam int unsigned CGC_HOLD_BIT = 1;
  localparam int unsigned CGC_EXP_BIT = 2;
  // cycle_generator_mode fields
  localparam int unsigned MODE_THR_LSB = 0;
  localparam int unsigned MODE_EXP_LSB = 4;
  localparam int unsigned DIV_W = 4;
  // status fields
  localparam int unsigned STS_STOP_BIT = 5;
  localparam int unsigned STS_THR_BIT = 6;
  localparam int unsigned STS_HF_BIT = 7;
  // reset values
  localparam logic [7:0] RST_CYCLE_GEN_MODE = 8'h13;
  localparam logic [7:0] RST_SERIAL_CLK = 8'h00;
  localparam logic [7:0] RST_TIMER_CLK_A = 8'h00;
  localparam logic [7:0] RST_TIMER_CLK_B = 8'h00;
  localparam logic [7:0] RST_CLK_GATING = 8'h00;
  // idle window before the throttler slows the clocks
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned IDLE_TIME_NS = 5000;
  localparam int unsigned IDLE_CYCLES = IDLE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned IDLE_W = 10;
  typedef enum logic [4:0] {
    PS_OFF = 5'b0_0001,
    PS_SUSPEND = 5'b0_0010,
    PS_SLEEP = 5'b0_0100,
    PS_DOZE = 5'b0_1000,
    PS_ON = 5'b1_0000
  } power_state_e;
  typedef enum logic [3:0] {
    CPU_RUN = 4'b0001,
    CPU_HALT_STOP = 4'b0010,
    CPU_HOLD_STOP = 4'b0100,
    CPU_EXP_STOP = 4'b1000
  } cpu_state_e;
endpackage

// file: core/rate_divider.sv
// divider giving a one-cycle enable pulse every ratio+1 clocks
`timescale 1ns/1ps
module rate_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [clk_pkg::DIV_W-1:0] ratio,
  output logic tick
);
  typedef struct packed {
    logic [clk_pkg::DIV_W-1:0] cnt;
  } div_s;
  div_s cur_ff;
  div_s nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    tick = 1'b0;
    if (!run) begin
      nxt_cur.cnt = '0;
    end else if (cur_ff.cnt >= ratio) begin
      nxt_cur.cnt = '0;
      tick = 1'b1;
    end else begin
      nxt_cur.cnt = cur_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end
endmodule

// file: verification/cpu_core_model.sv
// processor core side: answers hold requests promptly or slowly
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hold_request,
  input wire logic slow,
  output logic hold_acknowledge
);
  logic [1:0] seen_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) seen_ff <= '0;
    else seen_ff <= {seen_ff[0], hold_request};
  end
  // ack only after a request, and withdrawn with it
  assign hold_acknowledge = hold_request & (slow ? seen_ff[1] : seen_ff[0]);
endmodule

// file: verification/power_state_clock_gating_props.sv
// port-level checks for the power-state clock gating block
`timescale 1ns/1ps
module pscg_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] power_state,
  input wire logic system_activity,
  input wire logic halt_cycle,
  input wire logic hold_acknowledge,
  input wire logic expansion_cycle,
  input wire logic lf_osc_enable,
  input wire logic hf_osc_enable,
  input wire logic refresh_enable,
  input wire logic pad_park,
  input wire logic throttle_request,
  input wire logic sys_clk_en,
  input wire logic cpu_clk_en,
  input wire logic exp_clk_en,
  input wire logic cycle_clk_en,
  input wire logic cpu_clk_stopped
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_lf_running: assert property (lf_osc_enable)
    else $error("slow oscillator stopped");
  chk_off_parked: assert property (power_state == 5'h01 |=>
    !hf_osc_enable && pad_park && !refresh_enable) else $error("off state");
  chk_suspend_refresh: assert property (power_state == 5'h02 |=>
    !hf_osc_enable && refresh_enable && !pad_park) else $error("suspend");
  chk_dead_clocks: assert property (power_state inside {5'h01, 5'h02}
    |=> !sys_clk_en && !cpu_clk_en) else $error("clock runs without osc");
  chk_on_full_speed: assert property (power_state == 5'h10 ##1
    power_state == 5'h10 |-> sys_clk_en && !throttle_request)
    else $error("on state throttled");
  chk_throttle_cause: assert property ($rose(throttle_request) |->
    $past(power_state) inside {5'h04, 5'h08} && !$past(system_activity))
    else $error("throttle without idle sleep");
  chk_stop_gates_cpu: assert property (cpu_clk_stopped |-> !cpu_clk_en)
    else $error("stopped cpu clock ticks");
  chk_stop_has_cause: assert property ($rose(cpu_clk_stopped) |->
    $past(hold_acknowledge) || $past(expansion_cycle) || $past(halt_cycle))
    else $error("cpu clock stopped without cause");
  chk_cycle_clk_src: assert property (cycle_clk_en ==
    (expansion_cycle ? exp_clk_en : cpu_clk_en)) else $error("cycle clock");
endmodule

bind power_state_clock_gating pscg_checker pscg_checker_i (.pclk, .presetn,
  .power_state, .system_activity, .halt_cycle, .hold_acknowledge,
  .expansion_cycle, .lf_osc_enable, .hf_osc_enable, .refresh_enable,
  .pad_park, .throttle_request, .sys_clk_en, .cpu_clk_en, .exp_clk_en,
  .cycle_clk_en, .cpu_clk_stopped);

// file: verification/tb_top.sv
// register, power-state and processor clock stop tests
`timescale 1ns/1ps
module tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] power_state;
  logic system_activity, halt_cycle, hold_request, hold_acknowledge;
  logic interrupt_request, nmi_request, expansion_cycle, rdy;
  logic lf_osc_enable, hf_osc_enable, refresh_enable, pad_park;
  logic throttle_request, sys_clk_en, cpu_clk_en, exp_clk_en;
  logic cycle_clk_en, cpu_clk_stopped;
  logic [7:0] sio_q, tma_q, tmb_q;
  int bad_count, samples_checked, n, i;
  logic [7:0] idx [5] = '{8'h01, 8'h0f, 8'h12, 8'h13, 8'hde};
  logic [7:0] rst [5] = '{8'h13, 8'h00, 8'h00, 8'h00, 8'h00};
  power_state_clock_gating power_state_clock_gating_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .power_state, .system_activity, .halt_cycle, .hold_request,
    .hold_acknowledge, .interrupt_request, .nmi_request, .expansion_cycle,
    .rdy, .lf_osc_enable, .hf_osc_enable, .refresh_enable, .pad_park,
    .throttle_request, .sys_clk_en, .cpu_clk_en, .exp_clk_en, .cycle_clk_en,
    .cpu_clk_stopped, .serial_clock_control(sio_q),
    .timer_clock_control_a(tma_q), .timer_clock_control_b(tmb_q));
  cpu_core_model cpu_core_model_i (.pclk, .presetn, .hold_request, .slow,
    .hold_acknowledge);
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // every transfer starts after an edge so psel is never set twice at once
  task apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= 32'(d);
    @(posedge pclk) penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1 && n < 20);
    if (pready !== 1) begin bad_count++; test_done; end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task wstop(input logic v);
    n = 0;
    while (cpu_clk_stopped !== v && n < 20) begin @(posedge pclk); n++; end
    chk("cpu_clk_stopped", cpu_clk_stopped, v);
    if (n >= 20) test_done;
  endtask
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, slow} = '0;
    {system_activity, halt_cycle, hold_request, interrupt_request} = '0;
    {nmi_request, expansion_cycle} = '0;
    rdy = 1;
    power_state = 5'h10;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    for (i = 0; i < 5; i++) begin
      apb(0, idx[i], 8'h00);
      chk("reset value", rd, 32'(rst[i]));
      apb(1, idx[i], 8'h5a ^ 8'(i));
      apb(0, idx[i], 8'h00);
      chk("readback", rd, 32'(8'h5a ^ 8'(i)));
    end
    chk("serial out", sio_q, 8'h5b);
    chk("timer a out", tma_q, 8'h58);
    chk("timer b out", tmb_q, 8'h59);
    apb(0, 8'h02, 8'h00);
    chk("unmapped error", {rd, er}, 1);
    apb(1, 8'h01, 8'h13);
    apb(1, 8'hde, 8'h00);
    for (i = 0; i < 5; i++) begin
      @(posedge pclk) power_state <= 5'(1 << i);
      repeat (3) @(posedge pclk);
      chk("hf osc", hf_osc_enable, i > 1);
      chk("refresh", refresh_enable, i > 0);
      chk("park", pad_park, i == 0);
      chk("lf osc", lf_osc_enable, 1);
      chk("sys clk", sys_clk_en, i > 1);
    end
    @(posedge pclk) power_state <= 5'h04;
    n = 0;
    while (throttle_request !== 1 && n < 1100) begin @(posedge pclk); n++; end
    chk("idle window", n > 990 && n < 1010, 1);
    if (n >= 1100) test_done;
    n = 0;
    repeat (16) begin @(posedge pclk); n += sys_clk_en; end
    chk("throttled ticks", n, 4);
    system_activity <= 1;
    repeat (3) @(posedge pclk);
    chk("throttle drop", throttle_request, 0);
    power_state <= 5'h10;
    system_activity <= 0;
    slow <= 1;
    hold_request <= 1;
    repeat (4) @(posedge pclk);
    chk("no stop after reset", cpu_clk_stopped, 0);
    apb(1, 8'hde, 8'h02);
    wstop(1);
    repeat (5) @(posedge pclk);
    chk("hold keeps stop", cpu_clk_stopped, 1);
    hold_request <= 0;
    wstop(0);
    apb(1, 8'hde, 8'h01);
    for (i = 0; i < 2; i++) begin
      @(posedge pclk) halt_cycle <= 1;
      @(posedge pclk) halt_cycle <= 0;
      wstop(1);
      {nmi_request, interrupt_request} <= 2'(1 << i);
      wstop(0);
      @(posedge pclk) {nmi_request, interrupt_request} <= 2'b00;
    end
    apb(1, 8'hde, 8'h04);
    @(posedge pclk) rdy <= 0;
    expansion_cycle <= 1;
    wstop(1);
    n = 0;
    repeat (8) begin @(posedge pclk); n += cycle_clk_en; end
    chk("expansion ticks", n, 4);
    chk("cpu clock held", cpu_clk_en, 0);
    rdy <= 1;
    wstop(0);
    @(posedge pclk) expansion_cycle <= 0;
    test_done;
  end
endmodule
